// ---- shared/tmra_pkg.sv ----
// Constants and types shared by the type A timer files
package tmra_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int PRE_W  = 8;

    // Base byte addresses of the three registers
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h600;
    localparam logic [ADDR_W-1:0] COUNT_OFS  = 12'h610;
    localparam logic [ADDR_W-1:0] PERIOD_OFS = 12'h620;

    // Alias selection held in address bits 3:2
    localparam int ALIAS_LSB = 2;
    localparam int BASE_LSB  = 4;
    localparam logic [1:0] ALIAS_WRITE = 2'h0;
    localparam logic [1:0] ALIAS_CLR   = 2'h1;
    localparam logic [1:0] ALIAS_SET   = 2'h2;
    localparam logic [1:0] ALIAS_INV   = 2'h3;

    // Control register fields
    localparam int CTRL_ON_BIT   = 15;
    localparam int CTRL_PRE_LSB  = 4;
    localparam int CTRL_SYNC_BIT = 2;
    localparam int CTRL_SRC_BIT  = 1;
    localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0000_8036;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  COUNT_RST  = 16'h0000;
    localparam logic [CNT_W-1:0]  PERIOD_RST = 16'hffff;

    // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [PRE_W-1:0] PRE_TC_1   = 8'h00;
    localparam logic [PRE_W-1:0] PRE_TC_8   = 8'h07;
    localparam logic [PRE_W-1:0] PRE_TC_64  = 8'h3f;
    localparam logic [PRE_W-1:0] PRE_TC_256 = 8'hff;

    typedef struct packed {
        logic       on;
        logic [1:0] prescale;
        logic       ext_sync;
        logic       ext_src;
    } tmra_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
    } tmra_bus_req_t;

endpackage

// ---- verilog/tmra_sync.sv ----
// Two flip-flop level synchroniser
module tmra_sync (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_async,
    output logic      o_sync
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// ---- verilog/tmra_timer.sv ----
// Type A 16-bit timer with Avalon-MM register slave

//Contract
// R1 - The count follows the external clock pin when the source bit is 1 and the core clock when it is 0.
// R2 - With the external source, the sync bit set adds a stage aligning the pin to the core clock, cleared uses it directly.
//      The code always passes the pin through the two flip-flop synchroniser; the sync bit only adds the pin_stage_q stage.
// R3 - With the core clock as source, the sync bit has no effect.
// R4 - Each register has clear, set and invert aliases at plus 0x4, 0x8 and 0xc, acting on the bits written as one.
// R5 - Unimplemented control bits, bit 3 and bit 0 among them, read zero and ignore writes.
// R6 - Software should not touch the registers in the cycle right after clearing the enable bit with a 1:1 divisor.
// R7 - While enabled the count steps once per selected edge and returns to zero on the edge after it equals the period.
module tmra_timer (
    input  wire logic                       I_CORE_CLK,
    input  wire logic                       I_ARST_N,
    input  wire logic [tmra_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input  wire logic                       I_AVS_READ,
    input  wire logic                       I_AVS_WRITE,
    input  wire logic [tmra_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
    output logic      [tmra_pkg::DATA_W-1:0] O_AVS_READDATA,
    output logic                            O_AVS_WAITREQUEST,
    input  wire logic                       I_EXT_TIMER_CLK_PIN,
    output logic                            O_PERIOD_MATCH
);

    // Bus request bundle
    tmra_pkg::tmra_bus_req_t req;

    assign req.address   = I_AVS_ADDRESS;
    assign req.read      = I_AVS_READ;
    assign req.write     = I_AVS_WRITE;
    assign req.writedata = I_AVS_WRITEDATA;

    // Registers
    logic [tmra_pkg::DATA_W-1:0] ctrl_q;
    logic [tmra_pkg::DATA_W-1:0] ctrl_d;
    logic [tmra_pkg::CNT_W-1:0]  count_q;
    logic [tmra_pkg::CNT_W-1:0]  count_d;
    logic [tmra_pkg::CNT_W-1:0]  period_q;
    logic [tmra_pkg::CNT_W-1:0]  period_d;
    logic [tmra_pkg::PRE_W-1:0]  pre_q;
    logic [tmra_pkg::PRE_W-1:0]  pre_d;
    logic                        ack_q;
    logic [tmra_pkg::DATA_W-1:0] rdata_q;
    logic                        match_q;
    logic                        pin_stage_q;
    logic                        pin_prev_q;

    // Decoded control fields
    tmra_pkg::tmra_ctrl_t ctrl;

    assign ctrl.on       = ctrl_q[tmra_pkg::CTRL_ON_BIT];
    assign ctrl.prescale = ctrl_q[tmra_pkg::CTRL_PRE_LSB +: 2];
    assign ctrl.ext_sync = ctrl_q[tmra_pkg::CTRL_SYNC_BIT];
    assign ctrl.ext_src  = ctrl_q[tmra_pkg::CTRL_SRC_BIT];

    // Bus handshake: one wait cycle for every access
    wire req_any    = req.read | req.write;
    wire req_accept = req_any & ack_q;
    wire wr_commit  = req.write & req_accept;
    wire ack_d      = req_any & ~ack_q;
    wire rd_load    = req.read & ~ack_q;

    assign O_AVS_WAITREQUEST = req_any & ~ack_q;

    // Address decode
    wire [tmra_pkg::ADDR_W-1:0] base_addr =
        {req.address[tmra_pkg::ADDR_W-1:tmra_pkg::BASE_LSB],
         {tmra_pkg::BASE_LSB{1'b0}}};
    wire [1:0] alias_op = req.address[tmra_pkg::ALIAS_LSB +: 2];

    wire sel_ctrl   = (base_addr == tmra_pkg::CTRL_OFS);
    wire sel_count  = (base_addr == tmra_pkg::COUNT_OFS);
    wire sel_period = (base_addr == tmra_pkg::PERIOD_OFS);

    wire wr_ctrl   = wr_commit & sel_ctrl;
    wire wr_count  = wr_commit & sel_count;
    wire wr_period = wr_commit & sel_period;

    // Write, clear, set or invert applied to an old register value
    function automatic logic [tmra_pkg::DATA_W-1:0] apply_alias(
        input logic [tmra_pkg::DATA_W-1:0] old_val,
        input logic [tmra_pkg::DATA_W-1:0] wdata,
        input logic [1:0]                  op
    );
        logic [tmra_pkg::DATA_W-1:0] res;
        res = old_val;
        case (op)
            tmra_pkg::ALIAS_WRITE: res = wdata;
            tmra_pkg::ALIAS_CLR:   res = old_val & ~wdata;
            tmra_pkg::ALIAS_SET:   res = old_val | wdata;
            tmra_pkg::ALIAS_INV:   res = old_val ^ wdata;
            default:               res = old_val;
        endcase
        return res;
    endfunction

    // Alias results for each register
    wire [tmra_pkg::DATA_W-1:0] ctrl_wr_val =
        apply_alias(ctrl_q, req.writedata, alias_op); // R4
    wire [tmra_pkg::DATA_W-1:0] count_wr_val =
        apply_alias({16'h0000, count_q}, req.writedata, alias_op); // R4
    wire [tmra_pkg::DATA_W-1:0] period_wr_val =
        apply_alias({16'h0000, period_q}, req.writedata, alias_op); // R4

    // Only implemented control bits are ever stored
    assign ctrl_d = wr_ctrl ? (ctrl_wr_val & tmra_pkg::CTRL_WMASK)
                            : ctrl_q; // R5

    assign period_d = wr_period ? period_wr_val[tmra_pkg::CNT_W-1:0]
                                : period_q;

    // External clock pin path
    logic pin_sync;

    tmra_sync u_pin_sync (
        .i_clk    (I_CORE_CLK),
        .i_arst_n (I_ARST_N),
        .i_async  (I_EXT_TIMER_CLK_PIN),
        .o_sync   (pin_sync)
    );

    // Extra alignment stage only in synchronised mode
    wire pin_level = ctrl.ext_sync ? pin_stage_q : pin_sync; // R2
    wire ext_edge  = pin_level & ~pin_prev_q;

    // Source select; sync bit plays no part for the core clock
    wire src_tick = ctrl.ext_src ? ext_edge : 1'b1; // R1 R3

    // Prescaler
    logic [tmra_pkg::PRE_W-1:0] pre_tc;

    always_comb begin
        case (ctrl.prescale)
            2'h0:    pre_tc = tmra_pkg::PRE_TC_1;
            2'h1:    pre_tc = tmra_pkg::PRE_TC_8;
            2'h2:    pre_tc = tmra_pkg::PRE_TC_64;
            2'h3:    pre_tc = tmra_pkg::PRE_TC_256;
            default: pre_tc = tmra_pkg::PRE_TC_1;
        endcase
    end

    wire pre_wrap  = (pre_q >= pre_tc);
    wire cnt_tick  = ctrl.on & src_tick & pre_wrap;
    wire at_period = (count_q == period_q);

    always_comb begin
        pre_d = pre_q;
        if (!ctrl.on) begin
            pre_d = '0;
        end else if (src_tick) begin
            pre_d = pre_wrap ? '0 : pre_q + 8'h01;
        end
    end

    // Counter: a bus write wins over a count step
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = count_wr_val[tmra_pkg::CNT_W-1:0];
        end else if (cnt_tick) begin
            count_d = at_period ? tmra_pkg::COUNT_RST
                                : count_q + 16'h0001; // R7
        end
    end

    // Read data
    logic [tmra_pkg::DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (sel_ctrl) begin
            rd_mux = ctrl_q & tmra_pkg::CTRL_WMASK; // R5
        end else if (sel_count) begin
            rd_mux = {16'h0000, count_q};
        end else if (sel_period) begin
            rd_mux = {16'h0000, period_q};
        end
    end

    assign O_AVS_READDATA = rdata_q;
    assign O_PERIOD_MATCH = match_q;

    // Flip-flops, one short process per register
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // Loaded in the wait cycle, stands until the next read
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_q <= '0;
        end else if (rd_load) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            ctrl_q <= tmra_pkg::CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            count_q <= tmra_pkg::COUNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            period_q <= tmra_pkg::PERIOD_RST;
        end else begin
            period_q <= period_d;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    // Extra stage, read only in synchronised mode
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_stage_q <= 1'b0;
        end else begin
            pin_stage_q <= pin_sync; // R2
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_level;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            match_q <= 1'b0;
        end else begin
            match_q <= cnt_tick & at_period & ~wr_count; // R7
        end
    end

endmodule

// ---- verification/tmra_timer_properties.sv ----
// Port checks for the type A timer
module tmra_timer_properties (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_ARST_N,
    input  wire logic [11:0] I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [31:0] O_AVS_READDATA,
    input  wire logic        O_AVS_WAITREQUEST,
    input  wire logic        I_EXT_TIMER_CLK_PIN,
    input  wire logic        O_PERIOD_MATCH
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic       on_q;
    wire        req = I_AVS_READ | I_AVS_WRITE;
    wire        rd_done = I_AVS_READ & ~O_AVS_WAITREQUEST;
    wire  [7:0] blk = I_AVS_ADDRESS[11:4];
    wire  [1:0] al = I_AVS_ADDRESS[3:2];
    wire        wb = I_AVS_WRITEDATA[15];
    wire        ctl_wr = I_AVS_WRITE & ~O_AVS_WAITREQUEST & (blk == 8'h60);
    wire        on_d = !ctl_wr ? on_q : al == 2'h0 ? wb :
                       al == 2'h1 ? on_q & ~wb : al == 2'h2 ? on_q | wb :
                       on_q ^ wb;
    // Mirror of the enable bit
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) on_q <= 1'b0;
        else on_q <= on_d;
    end
    property p_one_wait; req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("no answer");
    property p_first_wait; $rose(req) |-> O_AVS_WAITREQUEST; endproperty
    a_first_wait: assert property (p_first_wait) else $error("no wait");
    property p_rd_hold; !(I_AVS_READ && O_AVS_WAITREQUEST) |=>
        $stable(O_AVS_READDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
    property p_off_quiet; !on_q && $past(!on_q) && $past(!on_q, 2) |->
        !O_PERIOD_MATCH; endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("match off");
    property p_ctl_rd; rd_done && blk == 8'h60 |->
        (O_AVS_READDATA & ~32'h8036) == 0 && O_AVS_READDATA[15] == on_q;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
    property p_half; rd_done && (blk == 8'h61 || blk == 8'h62) |->
        O_AVS_READDATA[31:16] == 16'h0; endproperty
    a_half: assert property (p_half) else $error("upper half set");
    property p_unmap; rd_done && (blk < 8'h60 || blk > 8'h62) |->
        O_AVS_READDATA == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_idle_ready; !req |-> !O_AVS_WAITREQUEST; endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("stray wait");
endmodule

bind tmra_timer tmra_timer_properties u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_EXT_TIMER_CLK_PIN(I_EXT_TIMER_CLK_PIN), .O_PERIOD_MATCH(O_PERIOD_MATCH));

// ---- verification/tmra_timer_test.sv ----
// Self-checking bench for the type A timer
module tmra_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_n = 0, rd = 0, wr = 0, pin = 0;
    logic [11:0] adr = 0, b;
    logic [31:0] wd = 0, rdat, m, x, y, z, v;
    logic        wt, mt;
    int          n_fail = 0, n_tests = 0, cyc = 0, last = -1, k;
    logic [31:0] rq[$];
    int          gq[$];
    logic [31:0] ctl[3] = '{32'h8000, 32'h8004, 32'h8010};
    int          gap[3] = '{6, 6, 48};
    always #25 clk = ~clk;
    tmra_timer DUT (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wt),
        .I_EXT_TIMER_CLK_PIN(pin), .O_PERIOD_MATCH(mt));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g) begin
            n_fail++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            if (++n > 20) begin n_fail++; stop_test(); end
        end while (wt !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdk(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // Read results against the oldest note
    always @(posedge clk) begin
        if (rd && wt === 1'b0) begin
            if (rq.size() == 0) cmp(32'hdead, rdat);
            else cmp(rq.pop_front(), rdat);
        end
    end
    // Spacing of match pulses against the oldest note
    always @(negedge clk) begin
        cyc++;
        if (mt === 1'b1) begin
            if (last >= 0 && gq.size() > 0) cmp(gq.pop_front(), cyc - last);
            last = cyc;
        end
    end
    initial begin
        void'($urandom(32'h8bd53db5));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdk(12'h600, 32'h0);
        rdk(12'h610, 32'h0);
        rdk(12'h620, 32'hffff);
        rdk(12'h700, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            b = (i == 2) ? 12'h600 : 12'h610 + 12'h10 * i;
            m = (i == 2) ? 32'h8036 : 32'hffff;
            x = $urandom;
            y = $urandom;
            z = $urandom;
            v = $urandom;
            bus(1'b1, b, x);
            bus(1'b1, b + 12'h8, y);
            rdk(b, (x | y) & m);
            bus(1'b1, b + 12'h4, z);
            rdk(b, (x | y) & ~z & m);
            bus(1'b1, b + 12'hc, v);
            rdk(b, (((x | y) & ~z) ^ v) & m);
        end
        $display("alias test done");
        bus(1'b1, 12'h620, 32'h5);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 12'h600, 32'h0);
            bus(1'b1, 12'h610, 32'h0);
            repeat (4) @(posedge clk);
            last = -1;
            gq.push_back(gap[i]);
            bus(1'b1, 12'h600, ctl[i]);
            k = 0;
            while (gq.size() > 0 && k < 300) begin @(posedge clk); k++; end
            if (k == 300) begin n_fail++; stop_test(); end
        end
        $display("internal count test done");
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, 12'h600, 32'h0);
            bus(1'b1, 12'h610, 32'h0);
            bus(1'b1, 12'h620, 32'hffff);
            bus(1'b1, 12'h600, i ? 32'h8006 : 32'h8002);
            repeat (4) begin
                pin <= 1'b1;
                repeat (4) @(posedge clk);
                pin <= 1'b0;
                repeat (4) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            bus(1'b1, 12'h600, 32'h0);
            rdk(12'h610, 32'h4);
        end
        $display("external clock test done");
        stop_test();
    end
endmodule
